/* rtl/octal_switch_spi_control.sv */
`timescale 1ns/100ps
`include "octal_switch_params.svh"
module octal_switch_spi_control
    import octal_switch_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    input  wire logic              i_logic_supply_por,
    input  wire logic              i_battery_supply_por,
    input  wire logic              i_cs_n,
    input  wire logic              i_sclk,
    input  wire logic              i_sdi,
    output logic                   o_sdo,
    output logic                   o_sdo_oe_n,
    input  wire logic              i_direct_input_ch5,
    input  wire logic              i_direct_input_ch6,
    input  wire fault_in_s         i_fault,
    output logic [`CHAN_N-1:0]     o_drain_outputs,
    output logic [`CHAN_N-1:0]     o_det_current_en
);
    // ==========================================
    // Synchronisers
    logic [1:0] cs_q;
    logic [1:0] sclk_q;
    logic [1:0] sdi_q;
    logic [1:0] ch5_q;
    logic [1:0] ch6_q;
    logic [1:0] vdd_q;
    logic [1:0] battery_supply_q;

    always_ff @(posedge i_ref_clk) begin
        cs_q <= {cs_q[0], i_cs_n};
    end

    always_ff @(posedge i_ref_clk) begin
        sclk_q <= {sclk_q[0], i_sclk};
    end

    always_ff @(posedge i_ref_clk) begin
        sdi_q <= {sdi_q[0], i_sdi};
    end

    always_ff @(posedge i_ref_clk) begin
        ch5_q <= {ch5_q[0], i_direct_input_ch5};
    end

    always_ff @(posedge i_ref_clk) begin
        ch6_q <= {ch6_q[0], i_direct_input_ch6};
    end

    always_ff @(posedge i_ref_clk) begin
        vdd_q <= {vdd_q[0], i_logic_supply_por};
    end

    always_ff @(posedge i_ref_clk) begin
        battery_supply_q <= {battery_supply_q[0], i_battery_supply_por};
    end

    // ==========================================
    // Power-on reset
    logic por;

    assign por = i_rst | vdd_q[1] | battery_supply_q[1];

    // ==========================================
    // Edge detection
    logic cs_d;
    logic sclk_d;
    logic active;
    logic sclk_fall;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;

    always_ff @(posedge i_ref_clk) begin
        cs_d <= cs_q[1];
    end

    always_ff @(posedge i_ref_clk) begin
        sclk_d <= sclk_q[1];
    end

    assign active    = ~cs_q[1];
    assign sclk_fall = active & sclk_d & ~sclk_q[1];
    assign sclk_rise = active & ~sclk_d & sclk_q[1];
    assign cs_fall   = cs_d & ~cs_q[1];
    assign cs_rise   = ~cs_d & cs_q[1];

    // ==========================================
    // Fault status
    cmd_word_s                 cmd;
    fault_in_s                 fault_q1;
    fault_in_s                 fault_q2;
    wire logic [`CHAN_N-1:0]   eff_on;
    wire logic [`CHAN_N-1:0]   fault_now;
    logic [`WORD_W-1:0]        status_word;

    always_ff @(posedge i_ref_clk) begin
        fault_q1 <= i_fault;
    end

    always_ff @(posedge i_ref_clk) begin
        fault_q2 <= fault_q1;
    end

    genvar g;
    generate
        for (g = 0; g < `CHAN_N; g++) begin : g_on
            if (g == `CH5_BIT) begin : g_ch5
                assign eff_on[g] = cmd.out_on[g] | ch5_q[1];
            end else if (g == `CH6_BIT) begin : g_ch6
                assign eff_on[g] = cmd.out_on[g] | ch6_q[1];
            end else begin : g_cmd
                assign eff_on[g] = cmd.out_on[g];
            end
        end
    endgenerate

    generate
        for (g = 0; g < `CHAN_N; g++) begin : g_fault
            wire logic open_load_hit;
            assign open_load_hit = fault_q2.open_load[g]
                & ~eff_on[g] & cmd.det_en[g];
            assign fault_now[g] = fault_q2.over_temp[g]
                | fault_q2.over_current[g]
                | open_load_hit;
        end
    endgenerate

    assign status_word = {`STATUS_HI, fault_now};

    // ==========================================
    // Shift register and pulse count
    logic [`WORD_W-1:0]  shreg;
    logic [`PULSE_W-1:0] pulses;
    logic                over16;
    logic                frame_ok;

    always_ff @(posedge i_ref_clk) begin
        if (por) begin
            shreg <= '0;
        end else if (cs_fall) begin
            shreg <= status_word;
        end else if (sclk_fall) begin
            shreg <= {shreg[`WORD_W-2:0], sdi_q[1]};
        end
    end

    // ==========================================
    // Frame length check
    always_ff @(posedge i_ref_clk) begin
        if (por || cs_fall) begin
            pulses <= `PULSE_ZERO;
        end else if (sclk_fall) begin
            if (pulses == `MIN_PULSES - `PULSE_STEP) begin
                pulses <= `PULSE_ZERO;
            end else if (over16 && pulses == `CNT_MASK) begin
                pulses <= `PULSE_ZERO;
            end else begin
                pulses <= pulses + `PULSE_STEP;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (por || cs_fall) begin
            over16 <= 1'b0;
        end else if (sclk_fall && pulses == `MIN_PULSES - `PULSE_STEP) begin
            over16 <= 1'b1;
        end
    end

    assign frame_ok = over16 && (pulses == `PULSE_ZERO);

    // ==========================================
    // Serial output
    always_ff @(posedge i_ref_clk) begin
        if (por) begin
            o_sdo <= 1'b0;
        end else if (cs_fall) begin
            o_sdo <= status_word[`WORD_W-1];
        end else if (sclk_rise) begin
            o_sdo <= shreg[`WORD_W-1];
        end
    end

    // ==========================================
    // Output enable
    always_ff @(posedge i_ref_clk) begin
        if (por) begin
            o_sdo_oe_n <= 1'b1;
        end else begin
            o_sdo_oe_n <= cs_q[1];
        end
    end

    // ==========================================
    // Command register
    always_ff @(posedge i_ref_clk) begin
        if (por) begin
            cmd <= `CMD_RESET;
        end else if (cs_rise && frame_ok) begin
            cmd <= shreg;
        end
    end

    // ==========================================
    // Outputs
    assign o_drain_outputs  = eff_on;
    assign o_det_current_en = cmd.det_en;

endmodule : octal_switch_spi_control

/* rtl/octal_switch_params.svh */
// Function
// - Logic resets whenever logic supply or battery supply is applied.
// - Each frame swaps 16-bit command for 16-bit status, MSB first.
// - Command bits 0..7 switch channels 1..8; 1 on, 0 off.
// - Command bits 8..15 enable open-load current of channels 1..8.
// - Shifted command reaches outputs only at chip select rising edge.
// - With select low, data passes through the shift register for chaining.
// - Status bits 8..15 always read zero.
// - Status bits 0..7 report channel faults captured before the frame.
// - Overtemperature on a channel reports a one.
// - Short to supply or overcurrent reports a one.
// - Open load while commanded on is not reported.
// - Open load while off reports only with detection current enabled.
// - Sample data on clock falling edge, change output after rising edge.
// - Select high ignores clock and data; output not driven.
// - Only frames of 16 plus multiples of 8 pulses are acted on.
// - Direct inputs for channels 5 and 6 OR with their command bits.
`ifndef OCTAL_SWITCH_PARAMS_SVH
`define OCTAL_SWITCH_PARAMS_SVH
`define WORD_W        16
`define CHAN_N        8
`define OUT_LSB       0
`define DET_LSB       8
`define CMD_RESET     16'h0000
`define STATUS_HI     8'h00
`define PULSE_W       5
`define PULSE_ZERO    5'h00
`define PULSE_STEP    5'h01
`define MIN_PULSES    5'h10
`define CNT_MASK      5'h07
`define CH5_BIT       4
`define CH6_BIT       5
`endif

/* rtl/octal_switch_pkg.sv */
`include "octal_switch_params.svh"
package octal_switch_pkg;
    typedef struct packed {
        logic [`CHAN_N-1:0] det_en;
        logic [`CHAN_N-1:0] out_on;
    } cmd_word_s;
    typedef struct packed {
        logic [`CHAN_N-1:0] over_temp;
        logic [`CHAN_N-1:0] over_current;
        logic [`CHAN_N-1:0] open_load;
    } fault_in_s;
endpackage : octal_switch_pkg

/* sim/octal_switch_spi_control_assertions.sv */
`timescale 1ns/100ps
module octal_switch_checker (
    input wire logic       i_ref_clk,
    input wire logic       i_rst,
    input wire logic       i_logic_supply_por,
    input wire logic       i_battery_supply_por,
    input wire logic       i_cs_n,
    input wire logic       i_direct_input_ch5,
    input wire logic       i_direct_input_ch6,
    input wire logic       o_sdo_oe_n,
    input wire logic [7:0] o_drain_outputs,
    input wire logic [7:0] o_det_current_en
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // ==========================================
    // Sequences
    sequence idle_s; (i_cs_n && !i_logic_supply_por && !i_battery_supply_por)[*8]; endsequence
    sequence sel_s; (!i_cs_n)[*5]; endsequence
    // ==========================================
    // Checks
    reset_state_a: assert property ($fell(i_rst) |-> o_sdo_oe_n && o_det_current_en == 8'h00)
        else $error("state not cleared by reset");
    idle_float_a: assert property (idle_s |-> o_sdo_oe_n)
        else $error("output driven while idle");
    select_drive_a: assert property (sel_s ##3 !i_cs_n |-> !o_sdo_oe_n)
        else $error("output not driven while selected");
    det_hold_a: assert property ($changed(o_det_current_en) |-> i_cs_n)
        else $error("detect enables changed mid frame");
    drain_hold_a: assert property (sel_s |=> $stable(o_drain_outputs[3:0]))
        else $error("outputs changed mid frame");
    ch5_or_a: assert property (i_direct_input_ch5[*5] |-> o_drain_outputs[4])
        else $error("channel 5 direct input ignored");
    ch6_or_a: assert property (i_direct_input_ch6[*5] |-> o_drain_outputs[5])
        else $error("channel 6 direct input ignored");
    idle_hold_a: assert property (idle_s |=> $stable(o_drain_outputs[3:0]))
        else $error("outputs changed while idle");
endmodule : octal_switch_checker
bind octal_switch_spi_control octal_switch_checker u_chk (.i_ref_clk, .i_rst,
    .i_logic_supply_por, .i_battery_supply_por, .i_cs_n,
    .i_direct_input_ch5, .i_direct_input_ch6, .o_sdo_oe_n, .o_drain_outputs, .o_det_current_en);

/* sim/spi_master_model.sv */
`timescale 1ns/100ps
module spi_master_model (
    input  wire logic i_ref_clk,
    input  wire logic i_sdo,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_sdi
);
    initial {o_cs_n, o_sclk, o_sdi} = 3'b100;
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        @(posedge i_ref_clk) o_cs_n <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        for (int b = n - 1; b >= 0; b--) begin
            o_sdi <= tx[b];
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
            rx[b] = i_sdo;
            o_sclk <= 1'b0;
            repeat (4) @(posedge i_ref_clk);
        end
        o_cs_n <= 1'b1;
        o_sdi <= ~o_sdi;
        repeat (8) @(posedge i_ref_clk);
    endtask : xfer
    task automatic stray(input int n);
        for (int b = 0; b < n; b++) begin
            o_sdi <= 1'b1;
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
            o_sclk <= 1'b0;
            repeat (4) @(posedge i_ref_clk);
        end
    endtask : stray
endmodule : spi_master_model

/* sim/test_octal_switch_spi_control.sv */
`timescale 1ns/100ps
module test_octal_switch_spi_control import octal_switch_pkg::*;;
    logic        clk = 0, rst = 1, lpor = 0, bpor = 0, ch5 = 0, ch6 = 0;
    logic        cs_n, sclk, sdi, sdo, oe_n;
    logic [7:0]  drn, det;
    logic [31:0] rx;
    fault_in_s   flt = '0;
    int          failures = 0, check_count = 0;
    always #50 clk = ~clk;
    spi_master_model m (.i_ref_clk(clk), .i_sdo(sdo), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi));
    octal_switch_spi_control DUT (.i_ref_clk(clk), .i_rst(rst), .i_logic_supply_por(lpor),
        .i_battery_supply_por(bpor), .i_cs_n(cs_n), .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo),
        .o_sdo_oe_n(oe_n), .i_direct_input_ch5(ch5), .i_direct_input_ch6(ch6), .i_fault(flt),
        .o_drain_outputs(drn), .o_det_current_en(det));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic por(input bit b);
        @(posedge clk) {bpor, lpor} <= {b, !b};
        repeat (4) @(posedge clk);
        {bpor, lpor} <= 2'b00;
        repeat (6) @(posedge clk);
    endtask : por
    task automatic results;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("cmd", 32'h0000, {det, drn});
        flt <= {8'h00, 8'h00, 8'hFF};
        m.xfer(16, 32'hA55A, rx);
        chk("status", 32'h0000, rx);
        chk("cmd", 32'hA55A, {det, drn});
        flt <= {8'h01, 8'h02, 8'hFF};
        m.xfer(16, 32'h0000, rx);
        chk("status", 32'h00A7, rx);
        m.xfer(32, 32'h123400FF, rx);
        chk("chain", 32'h00031234, rx);
        chk("cmd", 32'h00FF, {det, drn});
        m.xfer(24, 32'hABF00F, rx);
        chk("cmd", 32'hF00F, {det, drn});
        m.xfer(20, 32'hFFFFF, rx);
        chk("cmd", 32'hF00F, {det, drn});
        m.stray(16);
        chk("cmd", 32'hF00F, {det, drn});
        chk("oe_n", 32'h1, oe_n);
        ch5 <= 1'b1;
        ch6 <= 1'b1;
        repeat (6) @(posedge clk);
        chk("direct", 32'hF03F, {det, drn});
        ch5 <= 1'b0;
        ch6 <= 1'b0;
        por(1);
        chk("cmd", 32'h0000, {det, drn});
        m.xfer(16, 32'hFFFF, rx);
        por(0);
        chk("cmd", 32'h0000, {det, drn});
        results();
    end
endmodule : test_octal_switch_spi_control
